/* File: common/sacc_consts.vh */
// Constants shared by the converter control design files
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
`define SACC_RES_BITS 18
`define SACC_MSB 17
`define SACC_MIDSCALE_SB 18'h20000
`define SACC_MAX_SB 18'h3FFFF
`define SACC_MIN_SB 18'h00000
`define SACC_MAX_TC 18'h1FFFF
`define SACC_MIN_TC 18'h20000
`define SACC_FMT_BINARY 1'b1
`define SACC_CLK_MHZ 250
`define SACC_MIN_PERIOD_NS 800
`define SACC_MIN_PERIOD_CYC ((`SACC_MIN_PERIOD_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_ACQ_NS 40
`define SACC_ACQ_CYC ((`SACC_ACQ_NS * `SACC_CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/sacc_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sacc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire ref_clk,
  input wire reset,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule
`default_nettype wire

/* File: rtl/sacc_coder.v */
// Output coding with format select and saturation codes
`timescale 1ns/1ps
`default_nettype none
`include "sacc_consts.vh"
module sacc_coder #(
  parameter W = 18
) (
  input wire [W-1:0] raw_code,
  input wire over_range,
  input wire under_range,
  input wire binary_fmt,
  output reg [W-1:0] coded
);
  always @* begin
    if (over_range) begin
      coded = binary_fmt ? `SACC_MAX_SB : `SACC_MAX_TC; // [RL7]
    end else if (under_range) begin
      coded = binary_fmt ? `SACC_MIN_SB : `SACC_MIN_TC; // [RL8]
    end else if (binary_fmt) begin
      coded = raw_code; // [RL6]
    end else begin
      coded = {~raw_code[W-1], raw_code[W-2:0]}; // [RL6]
    end
  end
endmodule
`default_nettype wire

/* File: rtl/sacc_top.v */
// Successive-approximation conversion control and result coding
// Contract
// RL1 - A conversion begins only after acquisition has ended and convert start has gone low.
// RL2 - The result is found by a binary search from the top bit down over 18 halving steps.
// RL3 - At the end of the search the code is formed and busy is then driven low.
// RL4 - The format select chooses straight binary or twos complement coding.
// RL5 - In full-width 18-bit parallel mode the format choice is not available.
// RL6 - Codes are 18 bits; midscale is 0x20000 in binary and 0x00000 in twos complement.
// RL7 - Overrange gives 0x3FFFF in binary or 0x1FFFF in twos complement.
// RL8 - Underrange gives 0x00000 in binary or 0x20000 in twos complement.
// RL9 - Each result belongs to its own sample and is ready when that conversion ends.
// RL10 - Conversions run at up to 1.25 MSPS and the host starts none faster.
// RL11 - A falling edge on convert start holds the sample and launches a conversion.
// RL12 - Under a power-down request a running conversion finishes and new ones are refused.
// RL13 - Busy rises when a conversion starts and stays high until the code is ready.
// RL14 - The host waits for busy to fall before reading and before a new start edge.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_consts.vh"
module sacc_top #(
  parameter W = 18,
  parameter ACQ_CYC = `SACC_ACQ_CYC,
  parameter PERIOD_CYC = `SACC_MIN_PERIOD_CYC
) (
  input wire ref_clk,
  input wire reset,
  input wire convert_start_n,
  input wire code_format_select,
  input wire full_width_mode,
  input wire power_down_request,
  input wire comp_above,
  input wire over_range,
  input wire under_range,
  output wire hold,
  output wire [W-1:0] trial_code,
  output wire busy,
  output wire powered_down,
  output wire [W-1:0] result,
  output wire result_valid
);
  localparam [3:0] ST_ACQ = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_CODE = 4'b1000;
  localparam [9:0] ACQ_N = ACQ_CYC[9:0];
  localparam [9:0] PER_N = PERIOD_CYC[9:0];

  wire cnv_n_s;
  wire fmt_s;
  wire pd_s;
  wire [W-1:0] coded;
  reg cnv_n_prev_q;
  reg [3:0] state_q;
  reg [W-1:0] sar_q;
  reg [W-1:0] bit_q;
  reg [9:0] acq_cnt_q;
  reg [9:0] per_cnt_q;
  reg ovr_q;
  reg und_q;
  reg [W-1:0] result_q;
  reg valid_q;
  reg fmt_q;

  sacc_sync #(.W(3), .INIT(3'b100)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d({convert_start_n, code_format_select, power_down_request}),
    .q({cnv_n_s, fmt_s, pd_s})
  );

  // Full-width parallel mode forces straight binary
  wire binary_fmt = full_width_mode ? `SACC_FMT_BINARY : fmt_s; // [RL5] [RL4]
  wire fall = cnv_n_prev_q & ~cnv_n_s; // [RL11]
  wire start_ok = (state_q == ST_IDLE) && fall && !pd_s && (per_cnt_q == 10'h000); // [RL1] [RL12] [RL10]

  sacc_coder #(.W(W)) u_coder (
    .raw_code(sar_q),
    .over_range(ovr_q),
    .under_range(und_q),
    .binary_fmt(fmt_q),
    .coded(coded)
  );

  always @(posedge ref_clk) begin
    if (reset) begin
      cnv_n_prev_q <= 1'b1;
      state_q <= ST_ACQ;
      sar_q <= {W{1'b0}};
      bit_q <= {W{1'b0}};
      acq_cnt_q <= 10'h000;
      per_cnt_q <= 10'h000;
      ovr_q <= 1'b0;
      und_q <= 1'b0;
      result_q <= {W{1'b0}};
      valid_q <= 1'b0;
      fmt_q <= 1'b1;
    end else begin
      cnv_n_prev_q <= cnv_n_s;
      valid_q <= 1'b0;
      if (per_cnt_q != 10'h000) begin
        per_cnt_q <= per_cnt_q - 10'h001;
      end
      case (state_q)
        ST_ACQ: begin
          if (acq_cnt_q >= ACQ_N - 10'h001) begin
            state_q <= ST_IDLE; // [RL1]
          end else begin
            acq_cnt_q <= acq_cnt_q + 10'h001;
          end
        end
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_CONV; // [RL11] [RL13]
            bit_q <= {1'b1, {(W-1){1'b0}}}; // [RL2]
            sar_q <= {1'b1, {(W-1){1'b0}}};
            per_cnt_q <= PER_N - 10'h001; // [RL10]
            fmt_q <= binary_fmt;
            ovr_q <= 1'b0;
            und_q <= 1'b0;
          end
        end
        ST_CONV: begin
          ovr_q <= ovr_q | over_range;
          und_q <= und_q | under_range;
          // Keep the trial bit if the input is above it, then try the next lower bit
          if (!comp_above) begin
            sar_q <= (sar_q & ~bit_q) | (bit_q >> 1); // [RL2]
          end else begin
            sar_q <= sar_q | (bit_q >> 1); // [RL2]
          end
          bit_q <= bit_q >> 1;
          if (bit_q[0]) begin
            state_q <= ST_CODE; // [RL3]
          end
        end
        ST_CODE: begin
          result_q <= coded; // [RL3] [RL9]
          valid_q <= 1'b1;
          acq_cnt_q <= 10'h000;
          state_q <= ST_ACQ; // [RL3]
        end
        default: begin
          state_q <= ST_ACQ;
        end
      endcase
    end
  end

  assign hold = (state_q == ST_CONV) || (state_q == ST_CODE); // [RL11]
  assign busy = hold; // [RL13] [RL3]
  assign trial_code = sar_q;
  assign powered_down = pd_s && (state_q != ST_CONV) && (state_q != ST_CODE); // [RL12]
  assign result = result_q; // [RL9]
  assign result_valid = valid_q;
endmodule
`default_nettype wire

/* File: dv/sacc_chk.sv */
// Port checker for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module sacc_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic convert_start_n,
  input wire logic full_width_mode,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic busy,
  input wire logic hold,
  input wire logic powered_down,
  input wire logic [17:0] result,
  input wire logic result_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  hold_edge_a: assert property ($rose(hold) |->
    !$past(convert_start_n, 3) && $past(convert_start_n, 4))
    else $error("hold without start edge");
  busy_len_a: assert property ($rose(busy) |-> ##18 busy ##1 !busy)
    else $error("busy length wrong");
  valid_fall_a: assert property (result_valid == $fell(busy))
    else $error("valid not at busy fall");
  result_hold_a: assert property (!result_valid |-> $stable(result))
    else $error("result changed");
  pd_start_a: assert property ($rose(busy) |-> !$past(powered_down))
    else $error("start while powered down");
  over_code_a: assert property (result_valid && over_range && $past(over_range, 19)
    |-> result == 18'h3FFFF || result == 18'h1FFFF) else $error("overrange code");
  under_code_a: assert property (result_valid && under_range && $past(under_range, 19)
    |-> result == 18'h00000 || result == 18'h20000) else $error("underrange code");
  full_width_a: assert property (result_valid && full_width_mode && over_range
    && $past(over_range, 19) |-> result == 18'h3FFFF) else $error("full width code");
  cover property (result_valid);
  cover property (result_valid && under_range);
  cover property (powered_down);
endmodule
bind sacc_top sacc_chk sacc_chk_inst (.ref_clk(ref_clk), .reset(reset),
  .convert_start_n(convert_start_n),
  .full_width_mode(full_width_mode), .over_range(over_range), .under_range(under_range),
  .busy(busy), .hold(hold), .powered_down(powered_down), .result(result),
  .result_valid(result_valid));
`default_nettype wire

/* File: dv/sacc_cmp_model.sv */
// Comparator model of the sampled input against the trial code
`timescale 1ns/1ps
`default_nettype none
module sacc_cmp_model (
  input wire logic [17:0] trial_code,
  input wire logic [17:0] target,
  output logic comp_above
);
  assign comp_above = (target >= trial_code);
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start_n = 1'b1;
  logic fmt = 1'b1;
  logic fw = 1'b0;
  logic pd = 1'b0;
  logic ovr = 1'b0;
  logic und = 1'b0;
  logic comp_above, busy, powered_down, result_valid;
  logic [17:0] target = 18'h00000;
  logic [17:0] trial_code, result;
  integer failures = 0;
  integer checks = 0;
  sacc_top #(.ACQ_CYC(2), .PERIOD_CYC(30)) sacc_top_inst (.ref_clk(ref_clk), .reset(reset),
    .convert_start_n(start_n), .code_format_select(fmt), .full_width_mode(fw),
    .power_down_request(pd), .comp_above(comp_above), .over_range(ovr), .under_range(und),
    .hold(), .trial_code(trial_code), .busy(busy), .powered_down(powered_down),
    .result(result), .result_valid(result_valid));
  sacc_cmp_model sacc_cmp_model_inst (.trial_code(trial_code), .target(target),
    .comp_above(comp_above));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task tally_and_finish;
    begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input logic [17:0] g, input logic [17:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task conv(input logic [17:0] t, input logic f, w, o, u, input logic [17:0] e);
    integer i;
    begin
      target <= t;
      fmt <= f;
      fw <= w;
      ovr <= o;
      und <= u;
      @(posedge ref_clk);
      start_n <= 1'b0;
      i = 0;
      while (result_valid !== 1'b1) begin
        @(negedge ref_clk);
        i = i + 1;
        if (i > 80) begin
          failures = failures + 1;
          tally_and_finish;
        end
      end
      chk(result, e);
      @(posedge ref_clk);
      start_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
    end
  endtask
  task codes_test;
    begin
      conv(18'h20000, 1'b1, 1'b0, 1'b0, 1'b0, 18'h20000);
      conv(18'h2ABCD, 1'b1, 1'b0, 1'b0, 1'b0, 18'h2ABCD);
      conv(18'h2ABCD, 1'b0, 1'b0, 1'b0, 1'b0, 18'h0ABCD);
      conv(18'h20000, 1'b0, 1'b0, 1'b0, 1'b0, 18'h00000);
      conv(18'h00001, 1'b0, 1'b0, 1'b0, 1'b0, 18'h20001);
    end
  endtask
  task range_test;
    begin
      conv(18'h12345, 1'b1, 1'b0, 1'b1, 1'b0, 18'h3FFFF);
      conv(18'h12345, 1'b0, 1'b0, 1'b1, 1'b0, 18'h1FFFF);
      conv(18'h12345, 1'b1, 1'b0, 1'b0, 1'b1, 18'h00000);
      conv(18'h12345, 1'b0, 1'b0, 1'b0, 1'b1, 18'h20000);
      conv(18'h0ABCD, 1'b0, 1'b1, 1'b0, 1'b0, 18'h0ABCD);
      conv(18'h12345, 1'b0, 1'b1, 1'b1, 1'b0, 18'h3FFFF);
    end
  endtask
  task pd_test;
    integer i, n;
    begin
      n = 0;
      pd <= 1'b1;
      repeat (5) @(posedge ref_clk);
      start_n <= 1'b0;
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge ref_clk);
        if (busy !== 1'b0) n = n + 1;
      end
      chk(n[17:0], 18'h00000);
      chk({17'h00000, powered_down}, 18'h00001);
      @(posedge ref_clk);
      start_n <= 1'b1;
      pd <= 1'b0;
    end
  endtask
  task rate_test;
    integer i, n;
    begin
      n = 0;
      repeat (5) @(posedge ref_clk);
      start_n <= 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
        @(negedge ref_clk);
        if (busy === 1'b1) n = n + 1;
      end
      chk(n[17:0], 18'h00013);
      @(posedge ref_clk);
      start_n <= 1'b1;
      @(posedge ref_clk);
      start_n <= 1'b0;
      n = 0;
      for (i = 0; i < 12; i = i + 1) begin
        @(negedge ref_clk);
        if (busy !== 1'b0) n = n + 1;
      end
      chk(n[17:0], 18'h00000);
      @(posedge ref_clk);
      start_n <= 1'b1;
      repeat (40) @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (20) @(posedge ref_clk);
    codes_test;
    range_test;
    pd_test;
    rate_test;
    tally_and_finish;
  end
endmodule
`default_nettype wire
